/* hdl/dam_ctrl_top.sv */
// Functional notes
// - Six independent attenuation registers, one per output channel.
// - Load control off: writes stored, active attenuators unchanged.
// - Load control off to load: all six stored values transfer together.
// - Rate setting steps attenuation every two or four sample periods.
// - Per-channel soft mute and DAC operation, plus infinite-zero mute.
// - After reset the zero pins show zero flags of channels one to six.
// - Register eleven switches zero pins to general-purpose outputs.
// - In output mode each pin drives its bit of register twelve.
// - Every control register can be read back.
// - Oversampling control selects 64 or 128 times the sample rate.
// - De-emphasis enable per channel pair and shared sample-rate setting.
// - System clock output enable and separate rate setting.
// - Output phase, filter roll-off and data format controls.
// - Four-pin serial control port; host drives clock, latch, data in.
// - Reset input active low; low holds the block in reset.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module dam_ctrl_top (
    input  wire logic        sys_clk,          // 125 MHz clock
    input  wire logic        rst_b,            // Async reset, active low
    input  wire logic        psel,             // APB select
    input  wire logic        penable,          // APB enable
    input  wire logic        pwrite,           // APB direction
    input  wire logic [7:0]  paddr,            // APB byte address
    input  wire logic [31:0] pwdata,           // APB write data
    output logic [31:0]      prdata,           // APB read data
    output logic             pready,           // APB ready
    output logic             pslverr,          // APB error
    input  wire logic        ctrlSerialClock,  // Host control clock
    input  wire logic        ctrlSerialIn,     // Host serial data
    input  wire logic        ctrlLatchStrobe,  // Frame latch
    output logic             ctrlSerialOut,    // Readback data
    input  wire logic        sampleTick,       // One pulse per sample
    input  wire logic [5:0]  zeroDetect,       // Zero detect per channel
    output logic [5:0]       zeroFlagPin,      // Zero flag or GPO pins
    output logic [5:0][7:0]  attenLevel,       // Active attenuator levels
    output logic [5:0]       softMuteCh,       // Soft mute per channel
    output logic [5:0]       dacOperateCh,     // DAC operate per channel
    output logic             infZeroMuteEn,    // Infinite zero mute
    output logic [2:0]       deemphPairEnable, // De-emphasis per pair
    output logic [1:0]       deemphRateSel,    // De-emphasis sample rate
    output logic             overSample128,    // 1: 128fs, 0: 64fs
    output logic             sysclkOutEnable,  // Clock output enable
    output logic             sysclkOutRate,    // Clock output rate
    output logic             outPhaseInv,      // Output phase inverted
    output logic             rollOffSel,       // Filter roll-off
    output logic [2:0]       audioFormat,      // Data interface format
    output logic             irq               // Interrupt, active high
);

    typedef struct packed {
        logic [5:0][7:0] attStore;
        logic [5:0][7:0] attTarget;
        logic [5:0][7:0] attActive;
        logic [5:0]      softMute;
        logic [5:0]      dacOp;
        logic [2:0]      opCtl;
        logic [5:0]      deemph;
        logic [6:0]      func;
        logic            gpoMode;
        logic [5:0]      gpoLevel;
        logic [6:0]      irqStat;
        logic [6:0]      irqMask;
        logic [1:0]      tickCnt;
        logic [5:0]      zeroPin;
        logic [5:0]      zeroPrev;
        logic            loadPrev;
        logic [31:0]     rdReg;
        logic            errReg;
    } dam_state_s;

    dam_state_s      st_r;
    dam_state_s      st_nxt;
    logic [6:0]      apbIdx;
    logic            apbOk;
    logic [1:0]      wrEn;
    logic [1:0][6:0] wrIdx;
    logic [1:0][7:0] wrDat;
    logic [6:0]      irqClr;
    logic [6:0]      irqEvt;
    logic            stepDue;
    logic            serWrStb;
    logic [6:0]      serIdx;
    logic [7:0]      serWrData;
    logic [7:0]      serRdData;
    logic [31:0]     serRdWord;

    ////////////////////////////////////////////////////////////////////////
    // Register readback decode, shared by APB and serial port
    function automatic logic [31:0] regRead(input dam_state_s s, input logic [6:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (idx)
            dam_pkg::IDX_MUTE:    v[5:0] = s.softMute;
            dam_pkg::IDX_DACOP:   v[5:0] = s.dacOp;
            dam_pkg::IDX_OPCTL:   v[2:0] = s.opCtl;
            dam_pkg::IDX_DEEMPH:  v[5:0] = s.deemph;
            dam_pkg::IDX_FUNC:    v[6:0] = s.func;
            dam_pkg::IDX_GPOMODE: v[0]   = s.gpoMode;
            dam_pkg::IDX_GPOLVL:  v[5:0] = s.gpoLevel;
            dam_pkg::IDX_IRQSTAT: v[6:0] = s.irqStat;
            dam_pkg::IDX_IRQMASK: v[6:0] = s.irqMask;
            default: begin
                if (idx < dam_pkg::IDX_MUTE) begin
                    v[7:0] = s.attStore[idx[2:0]];
                end
            end
        endcase
        return v;
    endfunction : regRead

    ////////////////////////////////////////////////////////////////////////
    // Serial control port
    dam_serial_port u_serial (
        .sys_clk         (sys_clk),
        .rst_b           (rst_b),
        .ctrlSerialClock (ctrlSerialClock),
        .ctrlSerialIn    (ctrlSerialIn),
        .ctrlLatchStrobe (ctrlLatchStrobe),
        .rdData          (serRdData),
        .ctrlSerialOut   (ctrlSerialOut),
        .wrStb           (serWrStb),
        .regIdx          (serIdx),
        .wrData          (serWrData)
    );

    assign serRdWord = regRead(st_r, serIdx);
    assign serRdData = serRdWord[7:0];

    // APB decode and write ports
    assign apbIdx   = {1'b0, paddr[7:2]};
    assign apbOk    = paddr[1:0] == 2'h0 && apbIdx <= dam_pkg::IDX_LAST;
    assign wrEn[0]  = psel && penable && pwrite && apbOk;
    assign wrIdx[0] = apbIdx;
    assign wrDat[0] = pwdata[7:0];
    assign wrEn[1]  = serWrStb && serIdx <= dam_pkg::IDX_LAST;
    assign wrIdx[1] = serIdx;
    assign wrDat[1] = serWrData;

    // Attenuation step timing
    assign stepDue = sampleTick && st_r.tickCnt == (st_r.opCtl[dam_pkg::OP_RATE_BIT] ?
                     dam_pkg::STEP_LAST_SLOW : dam_pkg::STEP_LAST_FAST);

    // Interrupt events: zero flag rises and attenuation load transfer
    assign irqEvt = {st_r.opCtl[dam_pkg::OP_LOAD_BIT] && !st_r.loadPrev,
                     zeroDetect & ~st_r.zeroPrev};

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        irqClr = 7'h00;
        // Read data and error captured in the setup phase
        if (psel && !penable) begin
            st_nxt.rdReg  = apbOk ? regRead(st_r, apbIdx) : 32'h0000_0000;
            st_nxt.errReg = !apbOk;
        end
        // Serial writes follow APB writes in the same cycle
        for (int p = 0; p < 2; p++) begin
            if (wrEn[p]) begin
                case (wrIdx[p])
                    dam_pkg::IDX_MUTE:    st_nxt.softMute = wrDat[p][5:0];
                    dam_pkg::IDX_DACOP:   st_nxt.dacOp    = wrDat[p][5:0];
                    dam_pkg::IDX_OPCTL:   st_nxt.opCtl    = wrDat[p][2:0];
                    dam_pkg::IDX_DEEMPH:  st_nxt.deemph   = wrDat[p][5:0];
                    dam_pkg::IDX_FUNC:    st_nxt.func     = wrDat[p][6:0];
                    dam_pkg::IDX_GPOMODE: st_nxt.gpoMode  = wrDat[p][dam_pkg::GPO_MODE_BIT];
                    dam_pkg::IDX_GPOLVL:  st_nxt.gpoLevel = wrDat[p][5:0];
                    dam_pkg::IDX_IRQSTAT: irqClr          = irqClr | wrDat[p][6:0];
                    dam_pkg::IDX_IRQMASK: st_nxt.irqMask  = wrDat[p][6:0];
                    default: begin
                        if (wrIdx[p] < dam_pkg::IDX_MUTE) begin
                            st_nxt.attStore[wrIdx[p][2:0]] = wrDat[p];
                        end
                    end
                endcase
            end
        end
        // Sticky status, set wins over clear
        st_nxt.irqStat = (st_r.irqStat & ~irqClr) | irqEvt;
        // Load held: all targets follow stored values together
        if (st_r.opCtl[dam_pkg::OP_LOAD_BIT]) begin
            st_nxt.attTarget = st_r.attStore;
        end
        // Sample period counter and ramp toward target
        if (sampleTick) begin
            st_nxt.tickCnt = stepDue ? 2'h0 : st_r.tickCnt + 2'h1;
        end
        for (int c = 0; c < 6; c++) begin
            if (stepDue && st_r.attActive[c] < st_r.attTarget[c]) begin
                st_nxt.attActive[c] = st_r.attActive[c] + 8'h01;
            end else if (stepDue && st_r.attActive[c] > st_r.attTarget[c]) begin
                st_nxt.attActive[c] = st_r.attActive[c] - 8'h01;
            end
        end
        // Zero pins: flags by default, register twelve in output mode
        st_nxt.zeroPin  = st_r.gpoMode ? st_r.gpoLevel : zeroDetect;
        st_nxt.zeroPrev = zeroDetect;
        st_nxt.loadPrev = st_r.opCtl[dam_pkg::OP_LOAD_BIT];
    end

    // State register with defaults
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r           <= '0;
            st_r.attStore  <= {6{dam_pkg::ATT_RST}};
            st_r.attTarget <= {6{dam_pkg::ATT_RST}};
            st_r.attActive <= {6{dam_pkg::ATT_RST}};
            st_r.softMute  <= dam_pkg::MUTE_RST;
            st_r.dacOp     <= dam_pkg::DACOP_RST;
            st_r.opCtl     <= dam_pkg::OPCTL_RST;
            st_r.deemph    <= dam_pkg::DEEMPH_RST;
            st_r.func      <= dam_pkg::FUNC_RST;
            st_r.gpoMode   <= dam_pkg::GPOMODE_RST;
            st_r.gpoLevel  <= dam_pkg::GPOLVL_RST;
            st_r.irqMask   <= dam_pkg::IRQMASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata           = st_r.rdReg;
    assign pslverr          = st_r.errReg && psel && penable;
    assign pready           = psel && penable;
    assign zeroFlagPin      = st_r.zeroPin;
    assign attenLevel       = st_r.attActive;
    assign softMuteCh       = st_r.softMute;
    assign dacOperateCh     = st_r.dacOp;
    assign infZeroMuteEn    = st_r.opCtl[dam_pkg::OP_IZD_BIT];
    assign deemphPairEnable = st_r.deemph[dam_pkg::DE_EN_LSB +: 3];
    assign deemphRateSel    = st_r.deemph[dam_pkg::DE_RATE_LSB +: 2];
    assign overSample128    = st_r.deemph[dam_pkg::DE_OS_BIT];
    assign sysclkOutEnable  = st_r.func[dam_pkg::FN_CKE_BIT];
    assign sysclkOutRate    = st_r.func[dam_pkg::FN_CKD_BIT];
    assign outPhaseInv      = st_r.func[dam_pkg::FN_PHASE_BIT];
    assign rollOffSel       = st_r.func[dam_pkg::FN_ROLL_BIT];
    assign audioFormat      = st_r.func[dam_pkg::FN_FMT_LSB +: 3];
    assign irq              = |(st_r.irqStat & st_r.irqMask);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_atten_hold_off: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        !st_r.opCtl[dam_pkg::OP_LOAD_BIT] |=> $stable(st_r.attTarget))
        else $error("Target moved while load control off");

    chk_atten_load_copy: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(st_r.opCtl[dam_pkg::OP_LOAD_BIT]) |=> st_r.attTarget == $past(st_r.attStore))
        else $error("Load transition did not transfer all values");

    // Bus write to an attenuation register, load held for two cycles
    sequence heldAttWrite;
        wrEn[0] && wrIdx[0] < dam_pkg::IDX_MUTE && !wrEn[1]
        && st_r.opCtl[dam_pkg::OP_LOAD_BIT] ##1 st_r.opCtl[dam_pkg::OP_LOAD_BIT];
    endsequence

    chk_load_follow: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        heldAttWrite |=> st_r.attTarget[$past(wrIdx[0][2:0], 2)] == $past(wrDat[0], 2))
        else $error("Attenuation write not applied with load held");

    chk_rate_step: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (st_r.attActive != $past(st_r.attActive)) |->
        $past(sampleTick) && $past(st_r.tickCnt) ==
        ($past(st_r.opCtl[dam_pkg::OP_RATE_BIT]) ? 2'h3 : 2'h1))
        else $error("Attenuation stepped off the selected rate");

    chk_flag_mode: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        !st_r.gpoMode |=> zeroFlagPin == $past(zeroDetect))
        else $error("Zero pin not showing zero flag");

    chk_gpo_level: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        st_r.gpoMode ##1 st_r.gpoMode |=> zeroFlagPin == $past(st_r.gpoLevel))
        else $error("Zero pin not showing output level");

    chk_gpo_switch: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (wrEn[0] && wrIdx[0] == dam_pkg::IDX_GPOMODE && !wrEn[1]) |=>
        st_r.gpoMode == $past(pwdata[0]))
        else $error("Register eleven did not set pin mode");

    chk_apb_readback: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (psel && !penable && !pwrite && apbIdx == dam_pkg::IDX_DACOP && apbOk) |=>
        prdata[5:0] == $past(st_r.dacOp))
        else $error("Readback differs from register");

    chk_irq_sticky: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (|irqEvt) |=> (st_r.irqStat & $past(irqEvt)) == $past(irqEvt))
        else $error("Event lost from status");

endmodule : dam_ctrl_top
`default_nettype wire

/* hdl/dam_pkg.sv */
`default_nettype none
package dam_pkg;

    // Register indices; byte address is four times the index
    localparam logic [6:0] IDX_ATT0    = 7'h00;  // Attenuation ch1..ch6 at 0..5
    localparam logic [6:0] IDX_MUTE    = 7'h06;
    localparam logic [6:0] IDX_DACOP   = 7'h07;
    localparam logic [6:0] IDX_OPCTL   = 7'h08;
    localparam logic [6:0] IDX_DEEMPH  = 7'h09;
    localparam logic [6:0] IDX_FUNC    = 7'h0a;
    localparam logic [6:0] IDX_GPOMODE = 7'h0b;  // Control register eleven
    localparam logic [6:0] IDX_GPOLVL  = 7'h0c;  // Control register twelve
    localparam logic [6:0] IDX_IRQSTAT = 7'h0d;
    localparam logic [6:0] IDX_IRQMASK = 7'h0e;
    localparam logic [6:0] IDX_LAST    = 7'h0e;

    // Field positions
    localparam int OP_LOAD_BIT  = 0;
    localparam int OP_RATE_BIT  = 1;
    localparam int OP_IZD_BIT   = 2;
    localparam int DE_EN_LSB    = 0;
    localparam int DE_RATE_LSB  = 3;
    localparam int DE_OS_BIT    = 5;
    localparam int FN_CKE_BIT   = 0;
    localparam int FN_CKD_BIT   = 1;
    localparam int FN_PHASE_BIT = 2;
    localparam int FN_ROLL_BIT  = 3;
    localparam int FN_FMT_LSB   = 4;
    localparam int GPO_MODE_BIT = 0;
    localparam int IRQ_LOAD_BIT = 6;

    // Reset values
    localparam logic [7:0] ATT_RST     = 8'hff;
    localparam logic [5:0] MUTE_RST    = 6'h00;
    localparam logic [5:0] DACOP_RST   = 6'h3f;
    localparam logic [2:0] OPCTL_RST   = 3'h0;
    localparam logic [5:0] DEEMPH_RST  = 6'h00;
    localparam logic [6:0] FUNC_RST    = 7'h00;
    localparam logic       GPOMODE_RST = 1'b0;
    localparam logic [5:0] GPOLVL_RST  = 6'h00;
    localparam logic [6:0] IRQMASK_RST = 7'h00;

    // Attenuation step spacing in sample periods, minus one for the counter
    localparam logic [1:0] STEP_LAST_FAST = 2'h1;  // Every 2/fs
    localparam logic [1:0] STEP_LAST_SLOW = 2'h3;  // Every 4/fs

    // Serial control frame
    localparam logic [4:0] SER_HDR_BITS   = 5'h08;
    localparam logic [4:0] SER_FRAME_BITS = 5'h10;

endpackage : dam_pkg
`default_nettype wire

/* hdl/dam_serial_port.sv */
`timescale 1ns/100ps
`default_nettype none
module dam_serial_port (
    input  wire logic       sys_clk,          // System clock
    input  wire logic       rst_b,            // Async reset, active low
    input  wire logic       ctrlSerialClock,  // Host control clock
    input  wire logic       ctrlSerialIn,     // Host serial data
    input  wire logic       ctrlLatchStrobe,  // Low during a frame
    input  wire logic [7:0] rdData,           // Readback of regIdx
    output logic            ctrlSerialOut,    // Readback serial data
    output logic            wrStb,            // One-cycle write pulse
    output logic [6:0]      regIdx,           // Register index of frame
    output logic [7:0]      wrData            // Write data of frame
);

    typedef struct packed {
        logic       sclkPrev;
        logic       latchPrev;
        logic [15:0] shiftIn;
        logic [4:0] bitCnt;
        logic       readFrame;
        logic       loadPend;
        logic [7:0] outShift;
        logic       sout;
        logic       wrStb;
        logic [6:0] idx;
        logic [7:0] data;
    } dam_ser_s;

    dam_ser_s st_r;
    dam_ser_s st_nxt;
    logic     sclkRise;
    logic     sclkFall;
    logic     inFrame;

    ////////////////////////////////////////////////////////////////////////
    // Edge detection on host clock and latch
    assign sclkRise = ctrlSerialClock && !st_r.sclkPrev;
    assign sclkFall = !ctrlSerialClock && st_r.sclkPrev;
    assign inFrame  = !ctrlLatchStrobe;

    // Frame shift, readback and write strobe
    always_comb begin
        st_nxt           = st_r;
        st_nxt.sclkPrev  = ctrlSerialClock;
        st_nxt.latchPrev = ctrlLatchStrobe;
        st_nxt.wrStb     = 1'b0;
        st_nxt.loadPend  = 1'b0;
        if (inFrame && st_r.latchPrev) begin
            st_nxt.bitCnt    = 5'h00;
            st_nxt.readFrame = 1'b0;
        end else if (inFrame && sclkRise && st_r.bitCnt != dam_pkg::SER_FRAME_BITS) begin
            st_nxt.shiftIn = {st_r.shiftIn[14:0], ctrlSerialIn};
            st_nxt.bitCnt  = st_r.bitCnt + 5'h01;
            if (st_r.bitCnt + 5'h01 == dam_pkg::SER_HDR_BITS) begin
                st_nxt.idx       = {st_r.shiftIn[5:0], ctrlSerialIn};
                st_nxt.readFrame = st_r.shiftIn[6];
                st_nxt.loadPend  = st_r.shiftIn[6];
            end
        end
        // Readback word loads one cycle after the header
        if (st_r.loadPend) begin
            st_nxt.outShift = rdData;
        end
        if (inFrame && sclkFall && st_r.readFrame && st_r.bitCnt >= dam_pkg::SER_HDR_BITS) begin
            st_nxt.sout     = st_r.outShift[7];
            st_nxt.outShift = {st_r.outShift[6:0], 1'b0};
        end
        // Latch rise ends the frame; full write frames commit
        if (!inFrame && !st_r.latchPrev) begin
            st_nxt.sout = 1'b0;
            if (st_r.bitCnt == dam_pkg::SER_FRAME_BITS && !st_r.readFrame) begin
                st_nxt.wrStb = 1'b1;
                st_nxt.data  = st_r.shiftIn[7:0];
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r           <= '0;
            st_r.sclkPrev  <= 1'b0;
            st_r.latchPrev <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ctrlSerialOut = st_r.sout;
    assign wrStb         = st_r.wrStb;
    assign regIdx        = st_r.idx;
    assign wrData        = st_r.data;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence fullWriteEnd;
        $rose(ctrlLatchStrobe) && st_r.bitCnt == dam_pkg::SER_FRAME_BITS && !st_r.readFrame;
    endsequence

    sequence headerRead;
        st_r.loadPend;
    endsequence

    chk_frame_write: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        fullWriteEnd |=> wrStb && wrData == $past(st_r.shiftIn[7:0]))
        else $error("Write frame did not commit");

    chk_read_load: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        headerRead |=> st_r.outShift == $past(rdData))
        else $error("Readback word not loaded");

endmodule : dam_serial_port
`default_nettype wire

/* verification/dam_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dam_host_model (
    input  wire logic sys_clk,         // Clock
    input  wire logic ctrlSerialOut,   // Readback data
    output logic      ctrlSerialClock, // Still outside frames
    output logic      ctrlSerialIn,    // Data to block
    output logic      ctrlLatchStrobe  // Low in frame
);
    // Idle pins
    initial {ctrlSerialClock, ctrlSerialIn, ctrlLatchStrobe} = 3'b001;
    // Hold a level three clocks
    task automatic hold();
        repeat (3) @(posedge sys_clk);
    endtask : hold
    // Frame of 16 bits, MSB first; read bits sampled before each rise
    task automatic xfer(input logic [15:0] f, output logic [7:0] r);
        ctrlLatchStrobe <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            ctrlSerialIn <= f[i];
            hold();
            r[i % 8] = ctrlSerialOut;
            ctrlSerialClock <= 1'b1;
            hold();
            ctrlSerialClock <= 1'b0;
        end
        hold();
        ctrlLatchStrobe <= 1'b1;
        ctrlSerialIn <= ~f[0]; // Released line flips
        hold();
    endtask : xfer
endmodule : dam_host_model
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(s, e, g) begin checked++; if ((g) !== (e)) begin errCount++; \
    $display("Error %s expected %0h seen %0h", s, e, g); end end
module tb_top;
    logic            sys_clk = 1'b0, rst_b = 1'b0, sampleTick = 1'b0, e;
    logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]      paddr = 8'h00, b;
    logic [31:0]     pwdata = 32'h0000_0000, seed = 32'h0000_a0ae, prdata, d;
    logic [5:0]      zeroDetect = 6'h00, zeroFlagPin, softMuteCh, dacOperateCh;
    logic [5:0][7:0] attenLevel;
    logic [2:0]      deemphPairEnable, audioFormat;
    logic [1:0]      deemphRateSel;
    logic            pready, pslverr, irq, ctrlSerialOut, ctrlSerialClock, ctrlSerialIn;
    logic            ctrlLatchStrobe, infZeroMuteEn, overSample128, sysclkOutEnable;
    logic            sysclkOutRate, outPhaseInv, rollOffSel;
    int              errCount = 0, checked = 0, mdl[15], i, n;
    dam_ctrl_top dam_ctrl_top_inst (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ctrlSerialClock, .ctrlSerialIn,
        .ctrlLatchStrobe, .ctrlSerialOut, .sampleTick, .zeroDetect, .zeroFlagPin,
        .attenLevel, .softMuteCh, .dacOperateCh, .infZeroMuteEn, .deemphPairEnable,
        .deemphRateSel, .overSample128, .sysclkOutEnable, .sysclkOutRate, .outPhaseInv,
        .rollOffSel, .audioFormat, .irq);
    dam_host_model dam_host_model_inst (.sys_clk, .ctrlSerialOut, .ctrlSerialClock,
        .ctrlSerialIn, .ctrlLatchStrobe);
    // Clock and one sample tick every two cycles
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) sampleTick <= ~sampleTick;
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // APB transfer; a read compares with v, a write updates the model
    task automatic acc(input logic w, input int x, input logic [31:0] v);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 8'(x * 4), v};
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge sys_clk);
        errCount += (n == 20);
        if (n == 20) print_verdict();
        e = pslverr;
        if (!w) `CHK("prdata", v, prdata)
        else mdl[x] = v & (x < 6 ? 8'hff : x == 8 ? 3'h7 : x == 11 ? 1'h1 :
                           x == 10 || x > 12 ? 7'h7f : 6'h3f);
        {psel, penable} <= 2'b00;
    endtask : acc
    // Reset, then defaults on every register
    task automatic dflt();
        rst_b <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int x = 0; x < 15; x++) begin
            mdl[x] = x < 6 ? 8'hff : x == 7 ? 6'h3f : 0;
            acc(1'b0, x, mdl[x]);
        end
    endtask : dflt
    // Control outputs and zero pins against the model
    task automatic fields();
        logic [25:0] ex;
        repeat (2) @(posedge sys_clk);
        ex = {mdl[6][5:0], mdl[7][5:0], mdl[8][2], mdl[9][5:0], mdl[10][6:0]};
        `CHK("fields", ex, ({softMuteCh, dacOperateCh, infZeroMuteEn, overSample128, deemphRateSel, deemphPairEnable, audioFormat, rollOffSel, outPhaseInv, sysclkOutRate, sysclkOutEnable}))
        `CHK("pins", mdl[11][0] ? mdl[12][5:0] : zeroDetect, zeroFlagPin)
    endtask : fields
    // Cycles until channel one moves
    task automatic chg(output int c);
        b = attenLevel[0];
        for (c = 0; c < 100 && attenLevel[0] === b; c++) @(posedge sys_clk);
        errCount += (c == 100);
        if (c == 100) print_verdict();
    endtask : chg
    // Wait for a channel to reach a level
    task automatic waitAtt(input int ch, input logic [7:0] v);
        for (n = 0; n < 400 && attenLevel[ch] !== v; n++) @(posedge sys_clk);
        `CHK("atten", v, attenLevel[ch])
        if (n == 400) print_verdict();
    endtask : waitAtt
    // Counts and verdict
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // Main sequence
    initial begin
        dflt();
        acc(1'b0, 15, 32'h0000_0000);
        `CHK("slverr", 1'b1, e)
        zeroDetect <= 6'(rnd());
        repeat (14) begin
            i = 6 + rnd() % 7;
            acc(1'b1, i, rnd());
            fields();
            acc(1'b0, i, mdl[i]);
        end
        acc(1'b1, 11, 32'h0000_0000);
        acc(1'b1, 14, 32'h0000_0000);
        zeroDetect <= 6'h00;
        acc(1'b1, 13, 32'h0000_007f);
        zeroDetect <= 6'h3f;
        repeat (3) @(posedge sys_clk);
        acc(1'b0, 13, 32'h0000_003f);
        `CHK("irq", 1'b0, irq)
        acc(1'b1, 14, 32'h0000_0001);
        @(posedge sys_clk);
        `CHK("irq", 1'b1, irq)
        acc(1'b1, 13, 32'h0000_0001);
        acc(1'b0, 13, 32'h0000_003e);
        `CHK("irq", 1'b0, irq)
        acc(1'b1, 8, 32'h0000_0000);
        for (i = 0; i < 6; i++) acc(1'b1, i, 8'hf0 - i);
        acc(1'b1, 13, 32'h0000_007f);
        repeat (20) @(posedge sys_clk);
        `CHK("held", {6{8'hff}}, attenLevel)
        acc(1'b1, 8, 32'h0000_0001);
        chg(n);
        `CHK("step", {6{8'hfe}}, attenLevel)
        acc(1'b0, 13, 32'h0000_0040);
        chg(n);
        chg(n);
        `CHK("fast", 4, n)
        acc(1'b1, 8, 32'h0000_0003);
        chg(n);
        chg(n);
        `CHK("slow", 8, n)
        waitAtt(5, 8'heb);
        acc(1'b1, 0, 32'h0000_00f8);
        waitAtt(0, 8'hf8);
        acc(1'b1, 11, 32'h0000_0001);
        d = rnd();
        dam_host_model_inst.xfer({1'b0, 7'h0c, d[7:0]}, b);
        mdl[12] = d[5:0];
        fields();
        dam_host_model_inst.xfer({1'b1, 7'h07, 8'h00}, b);
        `CHK("serial", mdl[7][7:0], b)
        zeroDetect <= 6'h00;
        dflt();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
